// [hdl/mmad_camcopy.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmad_regs.svh"
module mmad_camcopy (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic start, // begin a table copy
	input wire logic [`MMAD_EE_AW-1:0] src, // first serial word index
	input wire logic [15:0] dst, // first data space address
	input wire logic [`MMAD_CP_LW-1:0] len, // words to copy
	output logic busy, // copy running
	output logic done, // one-cycle end pulse
	output logic err, // set with done when a step failed
	output logic req_valid, // access request
	output logic req_space, // 0 program, 1 data
	output logic req_write, // request is a write
	output logic [15:0] req_addr, // request address
	output logic [15:0] req_wdata, // write data
	input wire logic take, // request taken by the sequencer
	input wire logic ans_ack, // answer pulse
	input wire logic ans_err, // answer carries an address error
	input wire logic [15:0] ans_rdata // read data with the answer
);
	// ==========================================================
	// copy engine: read a serial word, write it to data space sram
	mmad_pkg::mmad_cp_t st_r;
	logic valid_r, done_r, err_r, busy_r;
	logic [`MMAD_EE_AW-1:0] src_r;
	logic [15:0] dst_r, data_r;
	logic [`MMAD_CP_LW-1:0] cnt_r;
	wire last = (cnt_r == `MMAD_CP_LW'(1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= mmad_pkg::CP_IDLE;
			busy_r <= 1'b0;
			valid_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
			src_r <= '0;
			dst_r <= '0;
			data_r <= '0;
			cnt_r <= '0;
		end else begin
			done_r <= 1'b0;
			if (take) begin
				valid_r <= 1'b0;
			end
			case (st_r)
				mmad_pkg::CP_IDLE: begin
					if (start) begin
						src_r <= src;
						dst_r <= dst;
						cnt_r <= len;
						err_r <= 1'b0;
						// an empty copy just reports completion
						st_r <= (len == '0) ? mmad_pkg::CP_IDLE : mmad_pkg::CP_RD;
						valid_r <= (len != '0);
						done_r <= (len == '0);
						busy_r <= (len != '0);
					end
				end
				mmad_pkg::CP_RD: begin
					if (ans_ack && ans_err) begin
						st_r <= mmad_pkg::CP_IDLE;
						done_r <= 1'b1;
						err_r <= 1'b1;
						busy_r <= 1'b0;
					end else if (ans_ack) begin
						data_r <= ans_rdata;
						st_r <= mmad_pkg::CP_WR;
						valid_r <= 1'b1;
					end
				end
				mmad_pkg::CP_WR: begin
					if (ans_ack && (ans_err || last)) begin
						st_r <= mmad_pkg::CP_IDLE;
						done_r <= 1'b1;
						err_r <= ans_err;
						busy_r <= 1'b0;
					end else if (ans_ack) begin
						src_r <= src_r + `MMAD_EE_AW'(1);
						dst_r <= dst_r + 16'h0001;
						cnt_r <= cnt_r - `MMAD_CP_LW'(1);
						st_r <= mmad_pkg::CP_RD;
						valid_r <= 1'b1;
					end
				end
				default: begin
					st_r <= mmad_pkg::CP_IDLE;
					busy_r <= 1'b0;
				end
			endcase
		end
	end

	// reads come from the serial window, writes land in data space
	assign req_space = (st_r == mmad_pkg::CP_WR);
	assign req_write = (st_r == mmad_pkg::CP_WR);
	assign req_addr = (st_r == mmad_pkg::CP_WR) ? dst_r : {2'b01, src_r};
	assign req_wdata = data_r;
	assign req_valid = valid_r;
	assign busy = busy_r;
	assign done = done_r;
	assign err = err_r;

	// the word answered by the serial read must be the one written next
	AST_COPY_SPACE: assert property (@(posedge clk) disable iff (rst)
		st_r == mmad_pkg::CP_RD && ans_ack && !ans_err |=> req_valid && req_write &&
		req_space && req_addr == dst_r && req_wdata == $past(ans_rdata))
		else $error("copy write not aimed at data space");
endmodule
`default_nettype wire

// [hdl/mmad_pkg.sv]
package mmad_pkg;
	// ==========================================================
	// decoded destination of one access
	typedef enum logic [1:0] {TGT_NONE, TGT_EE, TGT_ISR, TGT_XSR} mmad_tgt_t;
	// fitted serial memory capacity, as strapped on the size pins
	typedef enum logic [1:0] {EE_64K, EE_128K, EE_256K} mmad_eesz_t;
	// serial clock rate selection
	typedef enum logic [1:0] {SPI_1M, SPI_2M, SPI_5M} mmad_rate_t;
	// access sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CAP, ST_EE} mmad_st_t;
	// copy engine states
	typedef enum logic [1:0] {CP_IDLE, CP_RD, CP_WR} mmad_cp_t;
endpackage

// [hdl/mmad_regs.svh]
`ifndef MMAD_REGS_SVH
`define MMAD_REGS_SVH
// ==========================================================
// address map of both spaces
`define MMAD_EE_LO 16'h4000
`define MMAD_ISR_LO 16'h8000
`define MMAD_ISR_USER 16'h8200
`define MMAD_XSR_LO 16'h8800
`define MMAD_D_ISR_LO 16'h0800
`define MMAD_D_ISR_HI 16'h0fff
`define MMAD_D_XSR_LO 16'h8000
// ==========================================================
// target index widths: 16k serial words, 2k internal, 32k external
`define MMAD_EE_AW 14
`define MMAD_ISR_AW 11
`define MMAD_XSR_AW 15
`define MMAD_CP_LW 12
// ==========================================================
// serial clock rates in MHz and derived half periods in sys cycles
`define MMAD_SYS_MHZ 200
`define MMAD_SPI_MHZ_A 1
`define MMAD_SPI_MHZ_B 2
`define MMAD_SPI_MHZ_C 5
`define MMAD_HALF_A (`MMAD_SYS_MHZ / (2 * `MMAD_SPI_MHZ_A))
`define MMAD_HALF_B (`MMAD_SYS_MHZ / (2 * `MMAD_SPI_MHZ_B))
`define MMAD_HALF_C (`MMAD_SYS_MHZ / (2 * `MMAD_SPI_MHZ_C))
`define MMAD_HALF_W 7
`endif

// [hdl/mmad_spiclk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmad_regs.svh"
module mmad_spiclk (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic load, // take a new rate selection
	input wire logic [1:0] sel, // requested rate code
	output logic [1:0] rate, // rate in force
	output logic sck // serial clock to the serial memory
);
	// ==========================================================
	// rate selection
	logic [1:0] rate_r;
	logic [`MMAD_HALF_W-1:0] cnt_r;
	logic sck_r;
	wire sel_ok = (sel == mmad_pkg::SPI_1M) || (sel == mmad_pkg::SPI_2M) ||
		(sel == mmad_pkg::SPI_5M);
	wire [`MMAD_HALF_W-1:0] half = (rate_r == mmad_pkg::SPI_5M) ? `MMAD_HALF_W'(`MMAD_HALF_C) :
		(rate_r == mmad_pkg::SPI_2M) ? `MMAD_HALF_W'(`MMAD_HALF_B) :
		`MMAD_HALF_W'(`MMAD_HALF_A);
	wire half_end = (cnt_r >= half - `MMAD_HALF_W'(1));

	// reset always returns to the slowest rate; unknown codes are ignored
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_r <= mmad_pkg::SPI_1M;
		end else if (load && sel_ok) begin
			rate_r <= sel;
		end
	end

	// ==========================================================
	// divider; a rate change applies to the half period in progress, which ends at once if already past the new length
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			sck_r <= 1'b0;
		end else if (half_end) begin
			cnt_r <= '0;
			sck_r <= ~sck_r;
		end else begin
			cnt_r <= cnt_r + `MMAD_HALF_W'(1);
		end
	end

	assign rate = rate_r;
	assign sck = sck_r;

	AST_RATE_DEFAULT: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> rate_r == mmad_pkg::SPI_1M)
		else $error("serial rate not at slowest after reset");
endmodule
`default_nettype wire

// [hdl/mmad_top.sv]
// Notes on behaviour
// - two separate 64k word spaces, 16-bit words
// - program 0 to 3fffh is reserved, refused
// - program 4000h to 7fffh goes to serial memory; addresses past the fitted size are refused
// - serial memory 64, 128 or 256 kbit
// - serial clock 1, 2, 5 MHz; 1 MHz after reset
// - program 8000h-87ffh internal sram; 8000h-81ffh internal only
// - program 8200h-87ffh internal sram for user programs
// - external sram at program 8800h-ffffh when fitted
// - without external sram, 8800h-ffffh is invalid
// - data 800h-fffh aliases program 8000h-87ffh
// - external sram optionally mapped at data 8000h-ffffh
// - tables copied from serial memory into data sram
`timescale 1ns/100ps
`default_nettype none
`include "mmad_regs.svh"
module mmad_top (
	input wire logic CLK_SYS, // system clock, 200 MHz
	input wire logic RESET, // async reset, high
	input wire logic REQ_VALID, // access request
	output logic REQ_READY, // request may be taken
	input wire logic REQ_SPACE, // 0 program, 1 data
	input wire logic REQ_WRITE, // request is a write
	input wire logic REQ_PRIV, // internal use, opens 8000h-81ffh
	input wire logic [15:0] REQ_ADDR, // word address
	input wire logic [15:0] REQ_WDATA, // write data
	output logic ACK, // answer pulse
	output logic ADDR_ERR, // answer was refused
	output logic [15:0] RDATA, // read data, valid with ack
	input wire logic EXT_MEM_PRESENT, // external sram fitted
	input wire logic EXT_DATA_MAP, // external sram also in data space
	input wire logic [1:0] EE_SIZE, // serial memory capacity code
	input wire logic SPI_RATE_LOAD, // take new serial rate
	input wire logic [1:0] SPI_RATE_SEL, // serial rate code
	output logic [1:0] EE_RATE, // serial rate in force
	output logic EE_SCK, // serial clock
	output logic EE_REQ, // serial memory access pending
	output logic EE_WE, // serial access is a write
	output logic [`MMAD_EE_AW-1:0] EE_ADDR, // serial word index
	input wire logic EE_DONE, // serial access finished
	input wire logic [15:0] EE_RDATA, // serial read data
	output logic ISR_EN, // internal sram strobe
	output logic ISR_WE, // internal sram write
	output logic [`MMAD_ISR_AW-1:0] ISR_ADDR, // internal sram index
	input wire logic [15:0] ISR_RDATA, // internal sram data
	output logic XSR_EN, // external sram strobe
	output logic XSR_WE, // external sram write
	output logic [`MMAD_XSR_AW-1:0] XSR_ADDR, // external sram index
	input wire logic [15:0] XSR_RDATA, // external sram data
	output logic [15:0] MEM_WDATA, // write data to all targets
	input wire logic COPY_START, // start a table copy
	input wire logic [`MMAD_EE_AW-1:0] COPY_SRC, // serial source index
	input wire logic [15:0] COPY_DST, // data space destination
	input wire logic [`MMAD_CP_LW-1:0] COPY_LEN, // words to copy
	output logic COPY_BUSY, // copy running
	output logic COPY_DONE, // copy end pulse
	output logic COPY_ERR // copy failed
);
	// ==========================================================
	// decoding
	function automatic logic ee_fits(input logic [15:0] a, input logic [1:0] esz);
		case (esz)
			mmad_pkg::EE_64K: ee_fits = (a[13:12] == 2'h0);
			mmad_pkg::EE_128K: ee_fits = !a[13];
			default: ee_fits = 1'b1;
		endcase
	endfunction

	function automatic mmad_pkg::mmad_tgt_t decode(input logic dsp, input logic [15:0] a,
		input logic priv, input logic ext, input logic dmap, input logic [1:0] esz);
		decode = mmad_pkg::TGT_NONE;
		if (!dsp) begin
			if (a >= `MMAD_XSR_LO) begin
				if (ext) decode = mmad_pkg::TGT_XSR;
			end else if (a >= `MMAD_ISR_USER) begin
				decode = mmad_pkg::TGT_ISR;
			end else if (a >= `MMAD_ISR_LO) begin
				if (priv) decode = mmad_pkg::TGT_ISR;
			end else if (a >= `MMAD_EE_LO) begin
				if (ee_fits(a, esz)) decode = mmad_pkg::TGT_EE;
			end
		end else begin
			if (a >= `MMAD_D_XSR_LO) begin
				if (ext && dmap) decode = mmad_pkg::TGT_XSR;
			end else if (a >= `MMAD_D_ISR_LO && a <= `MMAD_D_ISR_HI) begin
				decode = mmad_pkg::TGT_ISR;
			end
		end
	endfunction

	mmad_pkg::mmad_st_t state_r, state_nxt;
	mmad_pkg::mmad_tgt_t tgt_r;
	logic ready_r, src_r, ack_r, err_r, cp_ack_r, cp_err_r;
	logic ee_req_r, ee_we_r, isr_en_r, isr_we_r, xsr_en_r, xsr_we_r;
	logic [`MMAD_EE_AW-1:0] ee_addr_r;
	logic [`MMAD_ISR_AW-1:0] isr_addr_r;
	logic [`MMAD_XSR_AW-1:0] xsr_addr_r;
	logic [15:0] wdata_r, rdata_r;
	logic cp_valid, cp_space, cp_write, cp_busy;
	logic [15:0] cp_addr, cp_wdata;

	// ==========================================================
	// request selection; the copy engine only runs while the host is held off
	wire host_take = REQ_VALID && ready_r;
	wire idle = (state_r == mmad_pkg::ST_IDLE);
	wire cp_take = cp_valid && idle && !host_take;
	wire take = host_take || cp_take;
	wire m_space = host_take ? REQ_SPACE : cp_space;
	wire m_write = host_take ? REQ_WRITE : cp_write;
	wire m_priv = host_take ? REQ_PRIV : 1'b1;
	wire [15:0] m_addr = host_take ? REQ_ADDR : cp_addr;
	wire [15:0] m_wdata = host_take ? REQ_WDATA : cp_wdata;
	wire mmad_pkg::mmad_tgt_t tgt = decode(m_space, m_addr, m_priv, EXT_MEM_PRESENT,
		EXT_DATA_MAP, EE_SIZE);
	wire is_ee = take && (tgt == mmad_pkg::TGT_EE);
	wire is_isr = take && (tgt == mmad_pkg::TGT_ISR);
	wire is_xsr = take && (tgt == mmad_pkg::TGT_XSR);
	wire refuse = take && (tgt == mmad_pkg::TGT_NONE);

	// answer timing: refusals answer at once, sram after the read slot
	wire done_now = refuse || (state_r == mmad_pkg::ST_CAP) ||
		(state_r == mmad_pkg::ST_EE && EE_DONE);
	wire src_now = idle ? cp_take : src_r;
	wire [15:0] ans_data = (state_r == mmad_pkg::ST_EE) ? EE_RDATA :
		(tgt_r == mmad_pkg::TGT_XSR) ? XSR_RDATA : ISR_RDATA;

	// ==========================================================
	// sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mmad_pkg::ST_IDLE: begin
				if (is_ee) state_nxt = mmad_pkg::ST_EE;
				else if (is_isr || is_xsr) state_nxt = mmad_pkg::ST_WAIT;
			end
			mmad_pkg::ST_WAIT: state_nxt = mmad_pkg::ST_CAP;
			mmad_pkg::ST_CAP: state_nxt = mmad_pkg::ST_IDLE;
			mmad_pkg::ST_EE: begin
				if (EE_DONE) state_nxt = mmad_pkg::ST_IDLE;
			end
			default: state_nxt = mmad_pkg::ST_IDLE;
		endcase
	end

	// ready falls on every take that reaches a target, and stays up after a refusal, so the host never overruns a pending access
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_r <= mmad_pkg::ST_IDLE;
			ready_r <= 1'b0;
			src_r <= 1'b0;
			tgt_r <= mmad_pkg::TGT_NONE;
		end else begin
			state_r <= state_nxt;
			ready_r <= (state_nxt == mmad_pkg::ST_IDLE) && !cp_busy && !COPY_START &&
				!cp_take;
			if (take) src_r <= cp_take;
			if (take) tgt_r <= tgt;
		end
	end

	// ==========================================================
	// target strobes; a refused access touches no target
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			isr_en_r <= 1'b0;
			isr_we_r <= 1'b0;
			xsr_en_r <= 1'b0;
			xsr_we_r <= 1'b0;
		end else begin
			isr_en_r <= is_isr;
			isr_we_r <= is_isr && m_write;
			xsr_en_r <= is_xsr;
			xsr_we_r <= is_xsr && m_write;
		end
	end

	// serial request holds until the serial engine reports completion
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ee_req_r <= 1'b0;
			ee_we_r <= 1'b0;
		end else if (is_ee) begin
			ee_req_r <= 1'b1;
			ee_we_r <= m_write;
		end else if (EE_DONE) begin
			ee_req_r <= 1'b0;
			ee_we_r <= 1'b0;
		end
	end

	// addresses: both views of the internal sram share the low index bits
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ee_addr_r <= '0;
			isr_addr_r <= '0;
			xsr_addr_r <= '0;
			wdata_r <= '0;
		end else if (take) begin
			ee_addr_r <= m_addr[`MMAD_EE_AW-1:0];
			isr_addr_r <= m_addr[`MMAD_ISR_AW-1:0];
			xsr_addr_r <= m_addr[`MMAD_XSR_AW-1:0];
			wdata_r <= m_wdata;
		end
	end

	// ==========================================================
	// answers, routed back to whichever side made the request
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ack_r <= 1'b0;
			err_r <= 1'b0;
			cp_ack_r <= 1'b0;
			cp_err_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r <= done_now && !src_now;
			err_r <= refuse && !src_now;
			cp_ack_r <= done_now && src_now;
			cp_err_r <= refuse && src_now;
			if (done_now) rdata_r <= refuse ? 16'h0000 : ans_data;
		end
	end

	// ==========================================================
	// serial clock and table copy
	mmad_spiclk u_spiclk (
		.clk(CLK_SYS),
		.rst(RESET),
		.load(SPI_RATE_LOAD),
		.sel(SPI_RATE_SEL),
		.rate(EE_RATE),
		.sck(EE_SCK)
	);

	mmad_camcopy u_copy (
		.clk(CLK_SYS),
		.rst(RESET),
		.start(COPY_START),
		.src(COPY_SRC),
		.dst(COPY_DST),
		.len(COPY_LEN),
		.busy(cp_busy),
		.done(COPY_DONE),
		.err(COPY_ERR),
		.req_valid(cp_valid),
		.req_space(cp_space),
		.req_write(cp_write),
		.req_addr(cp_addr),
		.req_wdata(cp_wdata),
		.take(cp_take),
		.ans_ack(cp_ack_r),
		.ans_err(cp_err_r),
		.ans_rdata(rdata_r)
	);

	assign COPY_BUSY = cp_busy;
	assign REQ_READY = ready_r;
	assign ACK = ack_r;
	assign ADDR_ERR = err_r;
	assign RDATA = rdata_r;
	assign EE_REQ = ee_req_r;
	assign EE_WE = ee_we_r;
	assign EE_ADDR = ee_addr_r;
	assign ISR_EN = isr_en_r;
	assign ISR_WE = isr_we_r;
	assign ISR_ADDR = isr_addr_r;
	assign XSR_EN = xsr_en_r;
	assign XSR_WE = xsr_we_r;
	assign XSR_ADDR = xsr_addr_r;
	assign MEM_WDATA = wdata_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	wire h_prog = host_take && !REQ_SPACE;
	wire h_data = host_take && REQ_SPACE;
	wire ans_any = ack_r || cp_ack_r;

	sequence s_sram_tail;
		1'b1 ##2 ans_any;
	endsequence

	sequence s_refused;
		ACK && ADDR_ERR && !ISR_EN && !XSR_EN && !EE_REQ;
	endsequence

	AST_LOW_RESERVED: assert property (h_prog && REQ_ADDR < `MMAD_EE_LO |=> s_refused)
		else $error("reserved low program access not refused");
	AST_EE_ROUTE: assert property (h_prog && REQ_ADDR[15:14] == 2'h1 &&
		EE_SIZE == mmad_pkg::EE_256K |=> EE_REQ && EE_ADDR == $past(REQ_ADDR[13:0]))
		else $error("serial window access not routed");
	AST_EE_SIZE: assert property (h_prog && REQ_ADDR[15:14] == 2'h1 &&
		REQ_ADDR[13:12] != 2'h0 && EE_SIZE == mmad_pkg::EE_64K |=> s_refused)
		else $error("access beyond small serial memory not refused");
	AST_ISR_PRIV: assert property (h_prog && !REQ_PRIV && REQ_ADDR[15:9] == 7'h40 |=>
		s_refused)
		else $error("internal-only sram area reached by user");
	AST_ISR_USER: assert property (h_prog && REQ_ADDR >= `MMAD_ISR_USER &&
		REQ_ADDR < `MMAD_XSR_LO |=> ISR_EN && ISR_ADDR == $past(REQ_ADDR[10:0]))
		else $error("user program sram not selected");
	AST_ISR_ANSWER: assert property (ISR_EN |-> s_sram_tail)
		else $error("internal sram answer not two cycles after strobe");
	AST_XSR_PROG: assert property (h_prog && REQ_ADDR >= `MMAD_XSR_LO &&
		EXT_MEM_PRESENT |=> XSR_EN && !ISR_EN)
		else $error("external sram not selected");
	AST_NO_EXT: assert property (h_prog && REQ_ADDR >= `MMAD_XSR_LO &&
		!EXT_MEM_PRESENT |=> s_refused)
		else $error("missing external sram access not refused");
	AST_DATA_ALIAS: assert property (h_data && REQ_ADDR >= `MMAD_D_ISR_LO &&
		REQ_ADDR <= `MMAD_D_ISR_HI |=> ISR_EN && ISR_ADDR == $past(REQ_ADDR[10:0]))
		else $error("data view of internal sram misrouted");
	AST_XSR_DATA: assert property (h_data && REQ_ADDR >= `MMAD_D_XSR_LO &&
		EXT_MEM_PRESENT && EXT_DATA_MAP |=> XSR_EN && XSR_ADDR == $past(REQ_ADDR[14:0]))
		else $error("external sram not mapped in data space");
	AST_ERR_QUIET: assert property (ADDR_ERR |-> ACK && $past(REQ_READY))
		else $error("address error without a taken request");
endmodule
`default_nettype wire

// [sim/mmad_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmad_regs.svh"
// ==========================================================
// memories behind the decoder: serial store, internal and external sram
module mmad_mem_model (
	input wire logic clk, // system clock
	input wire logic slow, // stretch serial answers
	input wire logic ee_req, // serial access pending
	input wire logic ee_we, // serial write
	input wire logic [`MMAD_EE_AW-1:0] ee_addr, // serial word index
	output logic ee_done, // serial access finished
	output logic [15:0] ee_rdata, // serial read data
	input wire logic isr_en, // internal strobe
	input wire logic isr_we, // internal write
	input wire logic [`MMAD_ISR_AW-1:0] isr_addr, // internal index
	output logic [15:0] isr_rdata, // internal data
	input wire logic xsr_en, // external strobe
	input wire logic xsr_we, // external write
	input wire logic [`MMAD_XSR_AW-1:0] xsr_addr, // external index
	output logic [15:0] xsr_rdata, // external data
	input wire logic [15:0] wdata // write data
);
	logic [15:0] ee [0:16383];
	logic [15:0] isr [0:2047];
	logic [15:0] xsr [0:32767];
	int wait_n;
	// fill with a pattern that the bench recomputes
	initial begin
		for (int i = 0; i < 32768; i++) begin
			if (i < 16384) ee[i] = 16'(i * 7 + 1);
			if (i < 2048) isr[i] = 16'(i * 7 + 2);
			xsr[i] = 16'(i * 7 + 3);
		end
		{ee_done, ee_rdata, isr_rdata, xsr_rdata} = '0;
		wait_n = 0;
	end
	// serial engine; the data line flips when idle, so a stale word never passes
	always @(posedge clk) begin
		ee_done <= 1'b0;
		ee_rdata <= ~ee_rdata;
		if (ee_req && !ee_done) begin
			if (wait_n < (slow ? 7 : 1)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				ee_done <= 1'b1;
				if (ee_we) ee[ee_addr] <= wdata;
				else ee_rdata <= ee[ee_addr];
			end
		end
	end
	// sram answers in the cycle after the strobe only
	always @(posedge clk) begin
		isr_rdata <= isr_en ? isr[isr_addr] : ~isr_rdata;
		xsr_rdata <= xsr_en ? xsr[xsr_addr] : ~xsr_rdata;
		if (isr_en && isr_we) isr[isr_addr] <= wdata;
		if (xsr_en && xsr_we) xsr[xsr_addr] <= wdata;
	end
endmodule
`default_nettype wire

// [sim/motion_memory_address_decoder_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "mmad_regs.svh"
module motion_memory_address_decoder_test;
	logic CLK_SYS, RESET, REQ_VALID, REQ_READY, REQ_SPACE, REQ_WRITE, REQ_PRIV, ACK, ADDR_ERR;
	logic EXT_MEM_PRESENT, EXT_DATA_MAP, SPI_RATE_LOAD, EE_SCK, EE_REQ, EE_WE, EE_DONE, slow;
	logic ISR_EN, ISR_WE, XSR_EN, XSR_WE, COPY_START, COPY_BUSY, COPY_DONE, COPY_ERR, ee_q;
	logic [1:0] EE_SIZE, SPI_RATE_SEL, EE_RATE;
	logic [15:0] REQ_ADDR, REQ_WDATA, RDATA, EE_RDATA, ISR_RDATA, XSR_RDATA, MEM_WDATA, COPY_DST;
	logic [`MMAD_EE_AW-1:0] EE_ADDR, COPY_SRC;
	logic [`MMAD_ISR_AW-1:0] ISR_ADDR;
	logic [`MMAD_XSR_AW-1:0] XSR_ADDR;
	logic [`MMAD_CP_LW-1:0] COPY_LEN;
	logic [31:0] seed = 32'd82977;
	logic [16:0] tbl [22] = '{17'h03fff, 17'h04000, 17'h04fff, 17'h05000, 17'h05fff, 17'h06000,
		17'h07fff, 17'h08000, 17'h081ff, 17'h08200, 17'h087ff, 17'h08800, 17'h0ffff, 17'h107ff,
		17'h10800, 17'h109ff, 17'h10a00, 17'h10fff, 17'h11000, 17'h17fff, 17'h18000, 17'h1ffff};
	int err_total, num_checks, strobes, n;
	int shw [int];
	// ==========================================================
	// device and memories
	mmad_top uut (.CLK_SYS, .RESET, .REQ_VALID, .REQ_READY, .REQ_SPACE, .REQ_WRITE, .REQ_PRIV,
		.REQ_ADDR, .REQ_WDATA, .ACK, .ADDR_ERR, .RDATA, .EXT_MEM_PRESENT, .EXT_DATA_MAP, .EE_SIZE,
		.SPI_RATE_LOAD, .SPI_RATE_SEL, .EE_RATE, .EE_SCK, .EE_REQ, .EE_WE, .EE_ADDR, .EE_DONE,
		.EE_RDATA, .ISR_EN, .ISR_WE, .ISR_ADDR, .ISR_RDATA, .XSR_EN, .XSR_WE, .XSR_ADDR,
		.XSR_RDATA, .MEM_WDATA, .COPY_START, .COPY_SRC, .COPY_DST, .COPY_LEN, .COPY_BUSY,
		.COPY_DONE, .COPY_ERR);
	mmad_mem_model pm (.clk(CLK_SYS), .slow(slow), .ee_req(EE_REQ), .ee_we(EE_WE),
		.ee_addr(EE_ADDR), .ee_done(EE_DONE), .ee_rdata(EE_RDATA), .isr_en(ISR_EN),
		.isr_we(ISR_WE), .isr_addr(ISR_ADDR), .isr_rdata(ISR_RDATA), .xsr_en(XSR_EN),
		.xsr_we(XSR_WE), .xsr_addr(XSR_ADDR), .xsr_rdata(XSR_RDATA), .wdata(MEM_WDATA));
	// ==========================================================
	// clock, strobe counter and watchdog
	initial begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	// one count per target access, so refused requests must leave it alone
	always @(posedge CLK_SYS) begin
		if (ISR_EN === 1'b1 || XSR_EN === 1'b1 || (EE_REQ === 1'b1 && ee_q !== 1'b1)) strobes++;
		ee_q = EE_REQ;
	end
	initial begin
		#450000;
		err_total++;
		close_out();
	end
	// ==========================================================
	// helpers
	task automatic close_out();
		if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [31:0] xr();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// reference map: 1 serial, 2 internal, 3 external, 0 refused
	function automatic void decode(input int sp, pv, a, output int t, idx);
		t = 0;
		idx = a - 32'h8000;
		if (sp == 0 && a >= 32'h4000 && a < 32'h8000) begin
			idx = a - 32'h4000;
			t = (idx < (32'h1000 << (EE_SIZE > 2 ? 2 : EE_SIZE))) ? 1 : 0;
		end else if (sp == 0 && a >= 32'h8000 && a < 32'h8800) begin
			t = (a >= 32'h8200 || pv) ? 2 : 0;
		end else if (sp == 1 && a >= 32'h0800 && a < 32'h1000) begin
			t = 2;
			idx = a - 32'h0800;
		end else if (a >= 32'h8000 && EXT_MEM_PRESENT && (sp == 0 || EXT_DATA_MAP)) begin
			t = 3;
		end
	endfunction
	function automatic logic [15:0] get(input int t, idx);
		return shw.exists(t * 65536 + idx) ? 16'(shw[t * 65536 + idx]) : 16'(idx * 7 + t);
	endfunction
	// one host access, held until taken, then judged against the reference
	task automatic acc(input logic sp, wr, pv, input logic [15:0] a, d);
		int t, idx, s0;
		decode(sp, pv, a, t, idx);
		@(posedge CLK_SYS);
		#1;
		{REQ_SPACE, REQ_WRITE, REQ_PRIV, REQ_ADDR, REQ_WDATA, REQ_VALID} = {sp, wr, pv, a, d, 1'b1};
		n = 0;
		while (REQ_READY !== 1'b1 && n < 300) begin
			@(posedge CLK_SYS);
			#1 n++;
		end
		s0 = strobes;
		@(posedge CLK_SYS);
		#1 REQ_VALID = 1'b0;
		n = 0;
		while (ACK !== 1'b1 && n < 300) begin
			@(posedge CLK_SYS);
			#1 n++;
		end
		chk(16'(ACK), 16'h0001);
		chk(16'(ADDR_ERR), 16'(t == 0));
		chk(16'(strobes - s0), 16'(t != 0));
		if (!wr) chk(RDATA, t == 0 ? 16'h0000 : get(t, idx));
		else if (t != 0) shw[t * 65536 + idx] = d;
	endtask
	task automatic do_reset();
		RESET = 1'b1;
		repeat (8) @(posedge CLK_SYS);
		#1 RESET = 1'b0;
		chk(16'(EE_RATE), 16'h0000);
	endtask
	// cycles between two serial clock edges, after syncing to the divider
	task automatic half_period(input int exp);
		logic s;
		for (int k = 0; k < 3; k++) begin
			s = EE_SCK;
			n = 0;
			while (EE_SCK === s && n < 400) begin
				@(posedge CLK_SYS);
				#1 n++;
			end
		end
		chk(16'(n), 16'(exp));
	endtask
	task automatic copy(input int s, d, l, input logic ex);
		{COPY_SRC, COPY_DST, COPY_LEN, COPY_START} = {14'(s), 16'(d), 12'(l), 1'b1};
		@(posedge CLK_SYS);
		#1 COPY_START = 1'b0;
		chk(16'(COPY_BUSY), 16'(l != 0));
		n = 0;
		while (COPY_DONE !== 1'b1 && n < 3000) begin
			@(posedge CLK_SYS);
			#1 n++;
		end
		chk(16'({COPY_DONE, COPY_BUSY}), 16'h0002);
		chk(16'(COPY_ERR), 16'(ex));
		for (int i = 0; i < l && !ex; i++) shw[2 * 65536 + d - 32'h0800 + i] = get(1, s + i);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{REQ_VALID, REQ_SPACE, REQ_WRITE, REQ_PRIV, REQ_ADDR, REQ_WDATA, slow} = '0;
		{EXT_MEM_PRESENT, EXT_DATA_MAP, EE_SIZE, SPI_RATE_LOAD, SPI_RATE_SEL} = '0;
		{COPY_START, COPY_SRC, COPY_DST, COPY_LEN, ee_q} = '0;
		{err_total, num_checks, strobes} = '0;
		RESET = 1'b1;
		repeat (8) @(posedge CLK_SYS);
		#1 RESET = 1'b0;
		chk(16'(EE_RATE), 16'h0000);
		half_period(100);
		// rate codes 1, 2, then 3 which must be ignored, then back to 0
		for (int r = 0; r < 4; r++) begin
			{SPI_RATE_SEL, SPI_RATE_LOAD} = {2'(r == 3 ? 0 : r + 1), 1'b1};
			@(posedge CLK_SYS);
			#1 SPI_RATE_LOAD = 1'b0;
			@(posedge CLK_SYS);
			#1 chk(16'(EE_RATE), 16'(r == 3 ? 0 : (r == 0 ? 1 : 2)));
			half_period(r == 3 ? 100 : (r == 0 ? 50 : 20));
		end
		SPI_RATE_SEL = 2'h2;
		SPI_RATE_LOAD = 1'b1;
		@(posedge CLK_SYS);
		#1 SPI_RATE_LOAD = 1'b0;
		do_reset();
		half_period(100);
		// every boundary address under every strap, write then read back
		foreach (tbl[i]) for (int c = 0; c < 32; c++) begin
			{REQ_PRIV, EXT_DATA_MAP, EXT_MEM_PRESENT, EE_SIZE} = 5'(c);
			slow = c[0] ^ c[2];
			acc(tbl[i][16], 1'b1, c[4], tbl[i][15:0], xr());
			acc(tbl[i][16], 1'b0, c[4], tbl[i][15:0], 16'h0000);
		end
		// random traffic across both spaces and all straps
		for (int i = 0; i < 300; i++) begin
			{slow, REQ_PRIV, EXT_DATA_MAP, EXT_MEM_PRESENT, EE_SIZE} = 6'(xr());
			acc(xr() % 2, xr() % 2, REQ_PRIV, xr(), xr());
		end
		// table copies: normal, empty, and one into a refused place
		{EE_SIZE, EXT_MEM_PRESENT, REQ_PRIV} = {2'h2, 1'b0, 1'b0};
		for (int i = 0; i < 3; i++) acc(1'b0, 1'b1, 1'b0, 16'h4005 + 16'(i), xr());
		copy(5, 32'h0a10, 3, 1'b0);
		for (int i = 0; i < 3; i++) acc(1'b1, 1'b0, 1'b0, 16'h0a10 + 16'(i), 16'h0000);
		copy(5, 32'h0a20, 0, 1'b0);
		copy(5, 32'h0100, 2, 1'b1);
		acc(1'b0, 1'b0, 1'b0, 16'h8a10, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
